/* File: hw/osc_ctrl_pkg.sv */
/*
  Constants for the internal oscillator control block: register map, field
  positions, reset values, frequency select codes and settling times.
  Assumes a 20 MHz APB clock and a 32-bit APB bus with byte addresses.
*/
//
// What this block does
// - A 16 MHz high-frequency source feeds a postscaler and mux chosen by the select field.
// - The high-frequency source runs when a HF setting is chosen and config is 100 or clock select is 1x.
// - The high-frequency ready flag is set while the high-frequency source runs.
// - The high-frequency locked flag is set once that source is within 2% of its final frequency.
// - The high-frequency stable flag is set once that source is within 0.5% of its final frequency.
// - A 500 kHz mid-frequency source gives six derived frequencies and shares the HF enable terms.
// - The mid-frequency ready flag is set while the mid-frequency source runs.
// - One trim value drives the shared base oscillator, so both HF and MF sources move together.
// - The trim is a 6-bit two's complement value, zero after reset, 1fh fastest and 20h slowest.
// - A trim write starts the shift at once and no flag reports that it has finished.
// - The trim never reaches the low-frequency source or its consumers.
// - An uncalibrated 31 kHz low-frequency source is selectable and clocks timer, watchdog and monitor.
// - The low-frequency source runs for select 0000-0001 with config 100 or clock select 1x, or when any consumer is on.
// - The low-frequency ready flag is set while the low-frequency source runs.
// - Logic runs from a fast start-up oscillator until the chosen source is ready (HF: stable), then switches over.

package osc_ctrl_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OSC_CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] OSC_STATUS_OFFSET = 8'h04;
  localparam logic [7:0] FREQ_TRIM_OFFSET = 8'h08;

  // oscillator_control fields
  localparam int CLK_SEL_LSB = 0;
  localparam int IFS_LSB = 3;
  localparam logic [1:0] CLK_SEL_RESET = 2'h0;
  localparam logic [3:0] IFS_RESET = 4'h7;

  // oscillator_status fields
  localparam int LF_READY_BIT = 0;
  localparam int MF_READY_BIT = 1;
  localparam int HF_STABLE_BIT = 2;
  localparam int HF_LOCKED_BIT = 3;
  localparam int HF_READY_BIT = 4;

  // frequency_trim field
  localparam int TRIM_WIDTH = 6;
  localparam logic [5:0] TRIM_RESET = 6'h00;

  // oscillator config word value that selects the internal source
  localparam logic [2:0] CONFIG_INTERNAL = 3'h4;

  // select codes: 0000-0001 low, 0010-0111 mid, 1000-1111 high
  localparam logic [3:0] IFS_MF_MIN = 4'h2;
  localparam logic [3:0] IFS_MF_TOP = 4'h7;
  localparam logic [3:0] IFS_HF_TOP = 4'hf;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 20;
  localparam int HF_READY_NS = 1000;
  localparam int HF_LOCK_NS = 10000;
  localparam int HF_STABLE_NS = 50000;
  localparam int MF_READY_NS = 1000;
  localparam int LF_READY_NS = 2000;
  localparam int HF_READY_CYC = (HF_READY_NS * CLK_MHZ + 999) / 1000;
  localparam int HF_LOCK_CYC = (HF_LOCK_NS * CLK_MHZ + 999) / 1000;
  localparam int HF_STABLE_CYC = (HF_STABLE_NS * CLK_MHZ + 999) / 1000;
  localparam int MF_READY_CYC = (MF_READY_NS * CLK_MHZ + 999) / 1000;
  localparam int LF_READY_CYC = (LF_READY_NS * CLK_MHZ + 999) / 1000;

  // where the system clock is taken from
  typedef enum logic [2:0] {
    ROUTE_FAST_START = 3'b000,
    ROUTE_HF = 3'b001,
    ROUTE_MF = 3'b010,
    ROUTE_LF = 3'b011,
    ROUTE_EXTERNAL = 3'b100
  } clk_route_t;

endpackage : osc_ctrl_pkg

/* File: hw/internal_oscillator_control.sv */
/*
  Internal oscillator control: APB registers for source select, clock
  select and frequency trim; enables for the analog sources; settle
  timers giving ready, locked and stable flags; system clock routing.
  Assumes the consumer enables and config select are driven from pclk
  logic, and that the analog oscillators follow the enables and trim.
*/
`timescale 1ns/10ps
`default_nettype none

module internal_oscillator_control
  import osc_ctrl_pkg::*;
#(
  parameter int CNT_WIDTH = 16,
  parameter int HF_READY_COUNT = osc_ctrl_pkg::HF_READY_CYC,
  parameter int HF_LOCK_COUNT = osc_ctrl_pkg::HF_LOCK_CYC,
  parameter int HF_STABLE_COUNT = osc_ctrl_pkg::HF_STABLE_CYC,
  parameter int MF_READY_COUNT = osc_ctrl_pkg::MF_READY_CYC,
  parameter int LF_READY_COUNT = osc_ctrl_pkg::LF_READY_CYC
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration and consumers of the low-frequency source
  input wire logic [2:0] oscillator_config_select,
  input wire logic power_up_timer_enable,
  input wire logic watchdog_enable,
  input wire logic fail_safe_clock_monitor_enable,
  // analog source controls
  output logic high_freq_internal_source_enable,
  output logic mid_freq_internal_source_enable,
  output logic low_freq_internal_source_enable,
  output logic [5:0] base_osc_trim,
  // system clock routing
  output logic [3:0] postscale_shift,
  output osc_ctrl_pkg::clk_route_t clock_route,
  output logic fast_start_enable
);

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  localparam int CNT_MAX = (1 << CNT_WIDTH) - 1;

  generate
    if (CNT_WIDTH < 2 || CNT_WIDTH > 30)
    begin : g_bad_width
      $error("CNT_WIDTH out of range");
    end
    if (HF_READY_COUNT < 1 || HF_LOCK_COUNT < HF_READY_COUNT ||
        HF_STABLE_COUNT < HF_LOCK_COUNT || HF_STABLE_COUNT >= CNT_MAX ||
        MF_READY_COUNT < 1 || MF_READY_COUNT >= CNT_MAX ||
        LF_READY_COUNT < 1 || LF_READY_COUNT >= CNT_MAX)
    begin : g_bad_count
      $error("settle counts do not fit the counters");
    end

    // register offsets: word aligned and apart from each other
    if (OSC_CONTROL_OFFSET[1:0] != 2'h0)
    begin : g_bad_ctrl_offset
      $error("control offset not word aligned");
    end
    if (OSC_STATUS_OFFSET[1:0] != 2'h0)
    begin : g_bad_status_offset
      $error("status offset not word aligned");
    end
    if (FREQ_TRIM_OFFSET[1:0] != 2'h0)
    begin : g_bad_trim_offset
      $error("trim offset not word aligned");
    end
    if (OSC_CONTROL_OFFSET == OSC_STATUS_OFFSET)
    begin : g_dup_ctrl_status
      $error("control and status offsets coincide");
    end
    if (OSC_CONTROL_OFFSET == FREQ_TRIM_OFFSET)
    begin : g_dup_ctrl_trim
      $error("control and trim offsets coincide");
    end
    if (OSC_STATUS_OFFSET == FREQ_TRIM_OFFSET)
    begin : g_dup_status_trim
      $error("status and trim offsets coincide");
    end

    // control fields in byte 0, the only byte that pstrb[0] guards
    if (CLK_SEL_LSB < 0 || CLK_SEL_LSB + 2 > 8)
    begin : g_bad_clk_sel_pos
      $error("clock select field outside byte 0");
    end
    if (IFS_LSB < 0 || IFS_LSB + 4 > 8)
    begin : g_bad_ifs_pos
      $error("frequency select field outside byte 0");
    end
    if (CLK_SEL_LSB + 2 > IFS_LSB && IFS_LSB + 4 > CLK_SEL_LSB)
    begin : g_ctrl_overlap
      $error("control fields overlap");
    end

    // status flags inside the word, one bit each
    if (LF_READY_BIT < 0 || LF_READY_BIT > 31)
    begin : g_bad_lf_ready_pos
      $error("lf ready bit outside the word");
    end
    if (MF_READY_BIT < 0 || MF_READY_BIT > 31)
    begin : g_bad_mf_ready_pos
      $error("mf ready bit outside the word");
    end
    if (HF_STABLE_BIT < 0 || HF_STABLE_BIT > 31)
    begin : g_bad_hf_stable_pos
      $error("hf stable bit outside the word");
    end
    if (HF_LOCKED_BIT < 0 || HF_LOCKED_BIT > 31)
    begin : g_bad_hf_locked_pos
      $error("hf locked bit outside the word");
    end
    if (HF_READY_BIT < 0 || HF_READY_BIT > 31)
    begin : g_bad_hf_ready_pos
      $error("hf ready bit outside the word");
    end
    if (((64'h1 << LF_READY_BIT) | (64'h1 << MF_READY_BIT) | (64'h1 << HF_STABLE_BIT) |
        (64'h1 << HF_LOCKED_BIT) | (64'h1 << HF_READY_BIT)) !=
        ((64'h1 << LF_READY_BIT) + (64'h1 << MF_READY_BIT) + (64'h1 << HF_STABLE_BIT) +
        (64'h1 << HF_LOCKED_BIT) + (64'h1 << HF_READY_BIT)))
    begin : g_dup_status_bit
      $error("two status flags share a bit");
    end

    // trim field fills the trim output exactly
    if (TRIM_WIDTH != 6)
    begin : g_bad_trim_width
      $error("trim width does not match the trim output");
    end

    // select codes: low, then mid, then high up to the top code
    if (IFS_MF_MIN == 4'h0 || IFS_MF_MIN > IFS_MF_TOP || IFS_MF_TOP >= IFS_HF_TOP)
    begin : g_bad_select_map
      $error("select code partition out of order");
    end
    if (IFS_HF_TOP != 4'hf)
    begin : g_bad_select_top
      $error("high select range must reach the top code");
    end

    // settle times are reckoned in whole pclk cycles
    if (CLK_MHZ < 1)
    begin : g_bad_clk
      $error("pclk frequency below 1 MHz");
    end
  endgenerate

  localparam logic [CNT_WIDTH-1:0] HF_READY_C = CNT_WIDTH'(HF_READY_COUNT);
  localparam logic [CNT_WIDTH-1:0] HF_LOCK_C = CNT_WIDTH'(HF_LOCK_COUNT);
  localparam logic [CNT_WIDTH-1:0] HF_STABLE_C = CNT_WIDTH'(HF_STABLE_COUNT);
  localparam logic [CNT_WIDTH-1:0] MF_READY_C = CNT_WIDTH'(MF_READY_COUNT);
  localparam logic [CNT_WIDTH-1:0] LF_READY_C = CNT_WIDTH'(LF_READY_COUNT);
  localparam logic [CNT_WIDTH-1:0] CNT_ONES = {CNT_WIDTH{1'b1}};

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] freq_select;
    logic [1:0] clock_select;
    logic [5:0] trim;
    logic [CNT_WIDTH-1:0] hf_cnt;
    logic [CNT_WIDTH-1:0] mf_cnt;
    logic [CNT_WIDTH-1:0] lf_cnt;
    logic hf_en;
    logic mf_en;
    logic lf_en;
    logic hf_ready;
    logic hf_locked;
    logic hf_stable;
    logic mf_ready;
    logic lf_ready;
    logic [3:0] shift;
    clk_route_t route;
    logic fast_start;
    logic [31:0] rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // settle timer: cleared while disabled, counts up and saturates
  function automatic logic [CNT_WIDTH-1:0] settle_step(
    input logic en,
    input logic [CNT_WIDTH-1:0] cnt
  );
    if (!en)
      settle_step = '0;
    else if (cnt == CNT_ONES)
      settle_step = cnt;
    else
      settle_step = cnt + CNT_WIDTH'(1);
  endfunction : settle_step

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic internal_sel;
    logic is_lf_set;
    logic is_mf_set;
    logic is_hf_set;
    logic consumer_on;
    logic setup;
    logic access_wr;
    logic [31:0] status_word;
    logic [31:0] control_word;
    internal_sel = 1'b0;
    is_lf_set = 1'b0;
    is_mf_set = 1'b0;
    is_hf_set = 1'b0;
    consumer_on = 1'b0;
    setup = 1'b0;
    access_wr = 1'b0;
    status_word = '0;
    control_word = '0;
    state_next = state_reg;

    // register writes land in the access phase
    access_wr = psel && penable && pwrite && pstrb[0];
    if (access_wr && paddr == OSC_CONTROL_OFFSET)
    begin
      state_next.freq_select = pwdata[IFS_LSB +: 4];
      state_next.clock_select = pwdata[CLK_SEL_LSB +: 2];
    end
    if (access_wr && paddr == FREQ_TRIM_OFFSET)
    begin
      state_next.trim = pwdata[TRIM_WIDTH-1:0];
    end

    // decode the select field into source families
    is_lf_set = state_reg.freq_select < IFS_MF_MIN;
    is_mf_set = !is_lf_set && state_reg.freq_select <= IFS_MF_TOP;
    is_hf_set = state_reg.freq_select > IFS_MF_TOP;
    internal_sel = (oscillator_config_select == CONFIG_INTERNAL) || state_reg.clock_select[1];
    consumer_on = power_up_timer_enable || watchdog_enable || fail_safe_clock_monitor_enable;

    // source enables
    state_next.hf_en = is_hf_set && internal_sel;
    state_next.mf_en = is_mf_set && internal_sel;
    state_next.lf_en = (is_lf_set && internal_sel) || consumer_on;

    // settle timers follow the registered enables
    state_next.hf_cnt = settle_step(state_reg.hf_en, state_reg.hf_cnt);
    state_next.mf_cnt = settle_step(state_reg.mf_en, state_reg.mf_cnt);
    state_next.lf_cnt = settle_step(state_reg.lf_en, state_reg.lf_cnt);

    // flags drop the cycle after their enable
    state_next.hf_ready = state_reg.hf_en && state_next.hf_cnt >= HF_READY_C;
    state_next.hf_locked = state_reg.hf_en && state_next.hf_cnt >= HF_LOCK_C;
    state_next.hf_stable = state_reg.hf_en && state_next.hf_cnt >= HF_STABLE_C;
    state_next.mf_ready = state_reg.mf_en && state_next.mf_cnt >= MF_READY_C;
    state_next.lf_ready = state_reg.lf_en && state_next.lf_cnt >= LF_READY_C;

    // postscaler: each step below the top code halves the source
    if (is_hf_set)
      state_next.shift = IFS_HF_TOP - state_reg.freq_select;
    else if (is_mf_set)
      state_next.shift = IFS_MF_TOP - state_reg.freq_select;
    else
      state_next.shift = 4'h0;

    // system clock routing, fast start until the chosen source settles
    state_next.fast_start = 1'b0;
    if (!internal_sel)
      state_next.route = ROUTE_EXTERNAL;
    else if (is_hf_set && state_reg.hf_stable)
      state_next.route = ROUTE_HF;
    else if (is_mf_set && state_reg.mf_ready)
      state_next.route = ROUTE_MF;
    else if (is_lf_set && state_reg.lf_ready)
      state_next.route = ROUTE_LF;
    else
    begin
      state_next.route = ROUTE_FAST_START;
      state_next.fast_start = 1'b1;
    end

    // read data captured in the setup phase
    control_word[IFS_LSB +: 4] = state_reg.freq_select;
    control_word[CLK_SEL_LSB +: 2] = state_reg.clock_select;
    status_word[HF_READY_BIT] = state_reg.hf_ready;
    status_word[HF_LOCKED_BIT] = state_reg.hf_locked;
    status_word[HF_STABLE_BIT] = state_reg.hf_stable;
    status_word[MF_READY_BIT] = state_reg.mf_ready;
    status_word[LF_READY_BIT] = state_reg.lf_ready;
    setup = psel && !penable;
    if (setup)
    begin
      case (paddr)
        OSC_CONTROL_OFFSET:
          state_next.rdata = control_word;
        OSC_STATUS_OFFSET:
          state_next.rdata = status_word;
        FREQ_TRIM_OFFSET:
          state_next.rdata = {26'h0, state_reg.trim};
        default:
          state_next.rdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= '0;
      state_reg.freq_select <= IFS_RESET;
      state_reg.clock_select <= CLK_SEL_RESET;
      state_reg.trim <= TRIM_RESET;
      state_reg.route <= ROUTE_FAST_START;
      state_reg.fast_start <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == OSC_CONTROL_OFFSET ||
    paddr == OSC_STATUS_OFFSET || paddr == FREQ_TRIM_OFFSET);
  assign prdata = state_reg.rdata;

  // one trim feeds the shared base oscillator, none goes to the low source
  assign base_osc_trim = state_reg.trim;
  assign high_freq_internal_source_enable = state_reg.hf_en;
  assign mid_freq_internal_source_enable = state_reg.mf_en;
  assign low_freq_internal_source_enable = state_reg.lf_en;
  assign postscale_shift = state_reg.shift;
  assign clock_route = state_reg.route;
  assign fast_start_enable = state_reg.fast_start;

endmodule : internal_oscillator_control

`default_nettype wire

/* File: verif/osc_ctrl_chk.sv */
/*
  Port checker for the oscillator control block.
  Bound to internal_oscillator_control and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none

module osc_ctrl_chk
  import osc_ctrl_pkg::*;
#(
  parameter int HF_STABLE_COUNT = 8
)
(
  // clock, reset and apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // consumers, source controls and routing
  input wire logic power_up_timer_enable,
  input wire logic watchdog_enable,
  input wire logic fail_safe_clock_monitor_enable,
  input wire logic high_freq_internal_source_enable,
  input wire logic mid_freq_internal_source_enable,
  input wire logic low_freq_internal_source_enable,
  input wire logic [5:0] base_osc_trim,
  input wire osc_ctrl_pkg::clk_route_t clock_route,
  input wire logic fast_start_enable
);
  // ----------------------------------------------------------------------
  // helper logic and assertions
  // ----------------------------------------------------------------------
  logic [15:0] hf_cnt_reg;
  logic [5:0] trim_last_reg;
  logic trim_wr;
  logic acc;
  assign acc = psel && penable;
  assign trim_wr = acc && pwrite && pstrb[0] && paddr == FREQ_TRIM_OFFSET;

  // cycles of hf enable, last trim written
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hf_cnt_reg <= 16'h0000;
      trim_last_reg <= 6'h00;
    end
    else
    begin
      if (!high_freq_internal_source_enable)
        hf_cnt_reg <= 16'h0000;
      else if (hf_cnt_reg != 16'hffff)
        hf_cnt_reg <= hf_cnt_reg + 16'h0001;
      if (trim_wr)
        trim_last_reg <= pwdata[5:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_lf_consumer: assert property (
    (power_up_timer_enable || watchdog_enable || fail_safe_clock_monitor_enable)
    |-> ##[1:2] low_freq_internal_source_enable) else $error("lf source off with consumer on");
  chk_fast_start: assert property (
    fast_start_enable == (clock_route == ROUTE_FAST_START)) else $error("fast start mismatch");
  chk_hf_gone: assert property (
    !high_freq_internal_source_enable [*4] |-> clock_route != ROUTE_HF)
    else $error("hf route without hf source");
  chk_hf_settle: assert property (
    clock_route == ROUTE_HF && high_freq_internal_source_enable |-> hf_cnt_reg >= HF_STABLE_COUNT)
    else $error("hf route before stable");
  chk_trim_cause: assert property (
    $changed(base_osc_trim) |-> $past(trim_wr) || $past(trim_wr, 2))
    else $error("trim changed without write");
  chk_trim_value: assert property (
    trim_wr |=> ##[0:1] base_osc_trim == trim_last_reg) else $error("trim output wrong");
  chk_slverr_map: assert property (
    acc |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08})) else $error("pslverr wrong");
  chk_unmapped_read: assert property (
    acc && !pwrite && pslverr |-> prdata == 32'h0) else $error("unmapped read not zero");
  chk_hf_mf_excl: assert property (
    high_freq_internal_source_enable |-> !mid_freq_internal_source_enable)
    else $error("hf and mf both on");
endmodule : osc_ctrl_chk

bind internal_oscillator_control osc_ctrl_chk #(.HF_STABLE_COUNT(HF_STABLE_COUNT)) chk_u (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pslverr,
  .power_up_timer_enable, .watchdog_enable, .fail_safe_clock_monitor_enable,
  .high_freq_internal_source_enable, .mid_freq_internal_source_enable,
  .low_freq_internal_source_enable, .base_osc_trim, .clock_route, .fast_start_enable);

`default_nettype wire

/* File: verif/internal_oscillator_control_tb.sv */
/*
  Self-checking bench for the oscillator control block.
  Assumes short settle counts 2/4/8/2/3 and zero wait apb.
*/
`timescale 1ns/10ps
`default_nettype none

module internal_oscillator_control_tb;
  import osc_ctrl_pkg::*;
  // ----------------------------------------------------------------------
  // stimulus, scoreboard and tests
  // ----------------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [2:0] oscillator_config_select = 3'h0;
  logic [2:0] cons = 3'h0;
  logic [31:0] prdata, v;
  logic pready, pslverr, hf_en, mf_en, lf_en, fs_en;
  logic [5:0] trim;
  logic [3:0] shift;
  clk_route_t route;
  logic [31:0] exp_q[$];
  int n_errors = 0;
  int n_checks = 0;
  int seed = 32'hf2da;
  int i;

  internal_oscillator_control #(.HF_READY_COUNT(2), .HF_LOCK_COUNT(4), .HF_STABLE_COUNT(8),
    .MF_READY_COUNT(2), .LF_READY_COUNT(3)) dut_u (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .oscillator_config_select, .power_up_timer_enable(cons[0]),
    .watchdog_enable(cons[1]), .fail_safe_clock_monitor_enable(cons[2]),
    .high_freq_internal_source_enable(hf_en), .mid_freq_internal_source_enable(mf_en),
    .low_freq_internal_source_enable(lf_en), .base_osc_trim(trim),
    .postscale_shift(shift), .clock_route(route), .fast_start_enable(fs_en));

  // clock
  initial
  begin
    forever #25 pclk = ~pclk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [31:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    if (!w)
      exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf, 32'h0);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'hf, e);
  endtask : rd

  task end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  // read data against oldest note
  always @(posedge pclk)
  begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      chk(prdata, exp_q.pop_front());
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    end_of_test;
  end

  // main sequence
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rd(8'h00, {25'h0, IFS_RESET, 1'b0, CLK_SEL_RESET});
    rd(8'h08, 32'h0);
    rd(8'h0c, 32'h0);
    wr(8'h04, 32'hffffffff);
    rd(8'h04, 32'h0);
    chk({29'h0, route}, {29'h0, ROUTE_EXTERNAL});
    $display("test reset done");
    for (i = 0; i < 16; i++)
    begin
      v = {25'h0, i[3:0], 3'h2};
      wr(8'h00, v);
      repeat (2) @(posedge pclk);
      chk({31'h0, fs_en}, {31'h0, i == 0 || i == 2 || i == 8});
      if (i == 8)
        rd(8'h04, 32'h10);
      repeat (28) @(posedge pclk);
      rd(8'h00, v);
      rd(8'h04, i < 2 ? 32'h1 : (i < 8 ? 32'h2 : 32'h1c));
      chk({29'h0, route}, {29'h0, i < 2 ? ROUTE_LF : (i < 8 ? ROUTE_MF : ROUTE_HF)});
      if (i >= 2)
        chk({28'h0, shift}, i < 8 ? 7 - i : 15 - i);
      chk({31'h0, hf_en}, {31'h0, i >= 8});
      chk({31'h0, mf_en}, {31'h0, i >= 2 && i < 8});
    end
    apb(1'b1, 8'h00, 32'h0, 4'h0, 32'h0);
    rd(8'h00, 32'h7a);
    $display("test select done");
    oscillator_config_select <= 3'h4;
    wr(8'h00, 32'h40);
    repeat (30) @(posedge pclk);
    rd(8'h04, 32'h1c);
    chk({28'h0, shift}, 32'h7);
    oscillator_config_select <= 3'($random(seed) & 3);
    repeat (30) @(posedge pclk);
    rd(8'h04, 32'h0);
    chk({29'h0, route}, {29'h0, ROUTE_EXTERNAL});
    for (i = 0; i < 3; i++)
    begin
      cons <= 3'h1 << i;
      repeat (10) @(posedge pclk);
      rd(8'h04, 32'h1);
      chk({31'h0, lf_en}, 32'h1);
    end
    $display("test consumer done");
    oscillator_config_select <= 3'h4;
    repeat (30) @(posedge pclk);
    for (i = 0; i < 6; i++)
    begin
      v = i == 0 ? 32'h1f : (i == 1 ? 32'h20 : $random(seed));
      wr(8'h08, v);
      rd(8'h08, v & 32'h3f);
      chk({26'h0, trim}, v & 32'h3f);
      rd(8'h04, 32'h1d);
    end
    $display("test trim done");
    end_of_test;
  end
endmodule : internal_oscillator_control_tb

`default_nettype wire
